// ### pkg/afe_cfg.svh
// Register map, field positions, reset values and counts of the status/config block.
// Assumes byte addresses on an 8-bit Avalon-MM address, one 32-bit word per register.
`ifndef AFE_CFG_SVH
`define AFE_CFG_SVH
`define AFE_IDX_STAT     8'h0c
`define AFE_IDX_CFG0     8'h0d
`define AFE_IDX_CRCV     8'h20
`define AFE_IDX_LOCK     8'h21
`define AFE_STAT_RST     24'ha10000
`define AFE_STAT_WMASK   24'hffc000
`define AFE_CFG0_RST     24'h386050
`define AFE_CFG0_WMASK   24'hffe0ff
`define AFE_BIT_COMMCRC  15
`define AFE_BIT_INTEN    14
`define AFE_BIT_IDLESEL  20
`define AFE_BIT_OFFCORR  23
`define AFE_BIT_GAINCORR 22
`define AFE_POS_STRENGTH_A   20
`define AFE_POS_BIAS     18
`define AFE_POS_PRESC    16
`define AFE_POS_OSR      13
`define AFE_UNLOCK_KEY   8'ha5
`define AFE_FLAGS_RST    6'h3f
`define AFE_GAIN_DLY     24
`define AFE_OSR_BASE     13'h020
`endif

// ### pkg/afe_pkg.sv
// Types shared by the status/config register block.
// Assumes nothing beyond a SystemVerilog compiler.
package afe_pkg;
  typedef enum logic [1:0] {
    AFE_BUS_IDLE = 2'h0,
    AFE_BUS_CRC  = 2'h1,
    AFE_BUS_DONE = 2'h3
  } afe_bus_st_t;
  typedef enum logic [1:0] {
    AFE_DITH_OFF = 2'h0,
    AFE_DITH_MIN = 2'h1,
    AFE_DITH_MED = 2'h2,
    AFE_DITH_MAX = 2'h3
  } afe_strength_a_t;
  typedef enum logic [1:0] {
    AFE_BIAS_HALF  = 2'h0,
    AFE_BIAS_TWO3  = 2'h1,
    AFE_BIAS_UNITY = 2'h2,
    AFE_BIAS_DOUBLE = 2'h3
  } afe_bias_t;
endpackage

// ### pkg/afe_rdy_if.sv
// Signals between the register block and its data-ready flag and pin logic.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface afe_rdy_if;
  logic [5:0] ev;
  logic       clr_rd;
  logic       alarm;
  logic       idle_sel;
  logic [5:0] flags;
  logic       pin_o;
  logic       pin_oe;
  modport regs (output ev, output clr_rd, output alarm, output idle_sel,
                input flags, input pin_o, input pin_oe);
  modport rdy (input ev, input clr_rd, input alarm, input idle_sel,
               output flags, output pin_o, output pin_oe);
endinterface

// ### rtl/afe_crc16.sv
// Combinational CRC-16 (polynomial 0x8005, zero seed) over a message, MSB first.
// Assumes the message is held stable by the caller for as long as the result is used.
`timescale 1ns/1ps
module afe_crc16 #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] i_msg,
  output logic      [15:0]  o_crc
);
  always_comb begin
    logic [15:0] c;
    c = 16'h0000;
    for (int i = W - 1; i >= 0; i--) begin
      if (c[15] ^ i_msg[i]) begin
        c = {c[14:0], 1'b0} ^ 16'h8005;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    o_crc = c;
  end
endmodule

// ### rtl/afe_rdy.sv
// Per-channel ready flags and the data-ready pin driver.
// Assumes events and the read-clear pulse come from logic on the same clock.
`timescale 1ns/1ps
`include "afe_cfg.svh"
module afe_rdy (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  afe_rdy_if.rdy    rif
);
  logic [5:0] flags_reg;
  logic [5:0] flags_next;
  logic       pin_o_reg;
  logic       pin_o_next;
  logic       pin_oe_reg;
  logic       pin_oe_next;

  always_comb begin
    flags_next = flags_reg;
    if (rif.clr_rd) begin
      flags_next = `AFE_FLAGS_RST;
    end
    // New data beats the read restore in the same cycle.
    flags_next = flags_next & ~rif.ev;
    pin_o_next  = !(rif.alarm || (|rif.ev));
    pin_oe_next = rif.alarm || (|rif.ev) || rif.idle_sel;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flags_reg  <= `AFE_FLAGS_RST;
      pin_o_reg  <= 1'b1;
      pin_oe_reg <= 1'b0;
    end else begin
      flags_reg  <= flags_next;
      pin_o_reg  <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign rif.flags  = flags_reg;
  assign rif.pin_o  = pin_o_reg;
  assign rif.pin_oe = pin_oe_reg;
endmodule

// ### rtl/afe_status_config_regs.sv
// Status/link-control and first configuration registers of a six-channel front end.
// Assumes an Avalon-MM master on the same clock and per-channel new-data pulses
// from the converter datapath, also on this clock.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "afe_cfg.svh"
module afe_status_config_regs #(
  parameter int GAIN_DLY = `AFE_GAIN_DLY
) (
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  input  wire logic [7:0]          i_avs_address,
  input  wire logic                i_avs_read,
  input  wire logic                i_avs_write,
  input  wire logic [31:0]         i_avs_writedata,
  input  wire logic [3:0]          i_avs_byteenable,
  output logic      [31:0]         o_avs_readdata,
  output logic                     o_avs_waitrequest,
  input  wire logic [5:0]          i_chan_new,
  input  wire logic                i_digital_master_clock_tick,
  output logic                     o_rdy_pin_o,
  output logic                     o_rdy_pin_oe,
  output logic      [15:0]         o_comm_crc,
  output logic                     o_comm_crc_valid,
  output logic                     o_offset_corr_en,
  output logic                     o_gain_corr_en,
  output afe_pkg::afe_strength_a_t     o_strength_a,
  output afe_pkg::afe_bias_t       o_bias_current_select,
  output logic                     o_analog_master_clock_en,
  output logic      [12:0]         o_osr_ratio,
  output logic      [7:0]          o_ref_trim
);
  import afe_pkg::*;

  afe_rdy_if rif ();

  afe_bus_st_t st_reg;
  afe_bus_st_t st_next;
  logic [23:0] stat_reg;
  logic [23:0] stat_next;
  logic [23:0] cfg0_reg;
  logic [23:0] cfg0_next;
  logic [7:0]  lock_key_reg;
  logic [7:0]  lock_key_next;
  logic        locked_reg;
  logic        locked_next;
  logic [15:0] ref_crc_reg;
  logic [15:0] ref_crc_next;
  logic        alarm_reg;
  logic        alarm_next;
  logic [23:0] rdata_reg;
  logic [23:0] rdata_next;
  logic [15:0] comm_crc_reg;
  logic [15:0] comm_crc_next;
  logic        crc_valid_reg;
  logic        crc_valid_next;
  logic [2:0]  presc_cnt_reg;
  logic [2:0]  presc_cnt_next;
  logic        analog_master_clock_reg;
  logic        analog_master_clock_next;
  logic [5:0]  pend_reg;
  logic [5:0]  pend_next;
  logic [5:0]  dly_reg [GAIN_DLY];
  logic [5:0]  dly_next [GAIN_DLY];

  logic        req;
  logic        commit;
  logic        wr_commit;
  logic        rd_commit;
  logic [23:0] rd_mux;
  logic [23:0] wdata;
  logic [15:0] cfg_crc;
  logic [15:0] comm_crc_w;
  logic        mismatch;
  logic [2:0]  div_m1;
  logic [5:0]  ev_w;

  assign req       = i_avs_read || i_avs_write;
  assign commit    = (st_reg == AFE_BUS_DONE);
  assign wr_commit = commit && i_avs_write;
  assign rd_commit = commit && i_avs_read;
  assign wdata     = i_avs_writedata[23:0];

  function automatic logic [23:0] merge(input logic [23:0] old, input logic [23:0] wd,
                                        input logic [3:0] be, input logic [23:0] mask);
    logic [23:0] res;
    res = old;
    for (int b = 0; b < 3; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return (res & mask) | (old & ~mask);
  endfunction

  // The checksum of the configuration covers every writable bit of both registers.
  afe_crc16 #(
    .W(48)
  ) u_cfg_crc (
    .i_msg ({stat_reg & `AFE_STAT_WMASK, cfg0_reg}),
    .o_crc (cfg_crc)
  );

  // The link checksum message is address, direction and the 24-bit data word.
  afe_crc16 #(
    .W(33)
  ) u_comm_crc (
    .i_msg ({i_avs_address, i_avs_write, i_avs_write ? wdata : rdata_reg}),
    .o_crc (comm_crc_w)
  );

  always_comb begin
    unique case (i_avs_address)
      `AFE_IDX_STAT << 2: rd_mux = {stat_reg[23:14], 2'h0, 6'h00, rif.flags};
      `AFE_IDX_CFG0 << 2: rd_mux = cfg0_reg & `AFE_CFG0_WMASK;
      `AFE_IDX_CRCV << 2: rd_mux = {8'h00, cfg_crc};
      `AFE_IDX_LOCK << 2: rd_mux = {16'h0000, lock_key_reg};
      default:            rd_mux = 24'h000000;
    endcase
  end

  // Bus sequencing: the answer comes one cycle after the request is seen, or two
  // when the link checksum is on, so the checksum is ready with the data.
  always_comb begin
    st_next        = st_reg;
    rdata_next     = rdata_reg;
    comm_crc_next  = comm_crc_reg;
    crc_valid_next = 1'b0;
    unique case (st_reg)
      AFE_BUS_IDLE: begin
        if (req) begin
          rdata_next = rd_mux;
          st_next    = stat_reg[`AFE_BIT_COMMCRC] ? AFE_BUS_CRC : AFE_BUS_DONE;
        end
      end
      AFE_BUS_CRC: begin
        comm_crc_next  = comm_crc_w;
        crc_valid_next = 1'b1;
        st_next        = AFE_BUS_DONE;
      end
      AFE_BUS_DONE: begin
        st_next = AFE_BUS_IDLE;
      end
      default: begin
        st_next = AFE_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg        <= AFE_BUS_IDLE;
      rdata_reg     <= 24'h000000;
      comm_crc_reg  <= 16'h0000;
      crc_valid_reg <= 1'b0;
    end else begin
      st_reg        <= st_next;
      rdata_reg     <= rdata_next;
      comm_crc_reg  <= comm_crc_next;
      crc_valid_reg <= crc_valid_next;
    end
  end

  assign o_avs_waitrequest = !commit;
  assign o_avs_readdata    = {8'h00, rdata_reg};
  assign o_comm_crc        = comm_crc_reg;
  assign o_comm_crc_valid  = crc_valid_reg && commit;

  // Registers and the checksum alarm.
  assign mismatch = locked_reg && (cfg_crc != ref_crc_reg);

  always_comb begin
    stat_next     = stat_reg;
    cfg0_next     = cfg0_reg;
    lock_key_next = lock_key_reg;
    locked_next   = locked_reg;
    ref_crc_next  = ref_crc_reg;
    alarm_next    = alarm_reg;
    if (wr_commit) begin
      if (i_avs_address == (`AFE_IDX_STAT << 2)) begin
        // Flag bits sit outside the write mask, so writes never reach them.
        stat_next = merge(stat_reg, wdata, i_avs_byteenable, `AFE_STAT_WMASK);
      end
      if (i_avs_address == (`AFE_IDX_CFG0 << 2)) begin
        cfg0_next = merge(cfg0_reg, wdata, i_avs_byteenable, `AFE_CFG0_WMASK);
      end
      if (i_avs_address == (`AFE_IDX_LOCK << 2) && i_avs_byteenable[0]) begin
        lock_key_next = wdata[7:0];
        if (wdata[7:0] == `AFE_UNLOCK_KEY) begin
          alarm_next  = 1'b0;
          locked_next = 1'b0;
        end else begin
          locked_next  = 1'b1;
          ref_crc_next = cfg_crc;
        end
      end
    end
    // A mismatch seen in the clearing cycle still raises the alarm.
    if (mismatch && stat_reg[`AFE_BIT_INTEN]) begin
      alarm_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stat_reg     <= `AFE_STAT_RST;
      cfg0_reg     <= `AFE_CFG0_RST;
      lock_key_reg <= 8'h00;
      locked_reg   <= 1'b0;
      ref_crc_reg  <= 16'h0000;
      alarm_reg    <= 1'b0;
    end else begin
      stat_reg     <= stat_next;
      cfg0_reg     <= cfg0_next;
      lock_key_reg <= lock_key_next;
      locked_reg   <= locked_next;
      ref_crc_reg  <= ref_crc_next;
      alarm_reg    <= alarm_next;
    end
  end

  // Analog clock prescaler, emitted as an enable pulse on the master clock.
  always_comb begin
    unique case (cfg0_reg[`AFE_POS_PRESC +: 2])
      2'h0: div_m1 = 3'h0;
      2'h1: div_m1 = 3'h1;
      2'h2: div_m1 = 3'h3;
      2'h3: div_m1 = 3'h7;
    endcase
    analog_master_clock_next     = (presc_cnt_reg >= div_m1);
    presc_cnt_next = analog_master_clock_next ? 3'h0 : presc_cnt_reg + 3'h1;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      presc_cnt_reg <= 3'h0;
      analog_master_clock_reg     <= 1'b0;
    end else begin
      presc_cnt_reg <= presc_cnt_next;
      analog_master_clock_reg     <= analog_master_clock_next;
    end
  end

  // Gain correction delay line, stepped once per digital clock period. Events that
  // arrive between steps are gathered so none is lost; the trade is up to one
  // period of extra jitter on the delayed pulse.
  always_comb begin
    pend_next = pend_reg;
    dly_next  = dly_reg;
    ev_w      = i_chan_new;
    if (cfg0_reg[`AFE_BIT_GAINCORR]) begin
      ev_w      = i_digital_master_clock_tick ? dly_reg[GAIN_DLY-1] : 6'h00;
      pend_next = i_digital_master_clock_tick ? 6'h00 : (pend_reg | i_chan_new);
      if (i_digital_master_clock_tick) begin
        dly_next[0] = pend_reg | i_chan_new;
        for (int k = 1; k < GAIN_DLY; k++) begin
          dly_next[k] = dly_reg[k-1];
        end
      end
    end else begin
      // Nothing is gathered or kept while the correction is bypassed, so turning
      // it on later never replays old results as fresh data.
      pend_next = 6'h00;
      for (int k = 0; k < GAIN_DLY; k++) begin
        dly_next[k] = 6'h00;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_reg <= 6'h00;
      for (int k = 0; k < GAIN_DLY; k++) begin
        dly_reg[k] <= 6'h00;
      end
    end else begin
      pend_reg <= pend_next;
      dly_reg  <= dly_next;
    end
  end

  assign rif.ev       = ev_w;
  assign rif.clr_rd   = rd_commit && (i_avs_address == (`AFE_IDX_STAT << 2));
  assign rif.alarm    = alarm_reg;
  assign rif.idle_sel = stat_reg[`AFE_BIT_IDLESEL];

  afe_rdy u_rdy (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .rif       (rif)
  );

  assign o_rdy_pin_o           = rif.pin_o;
  assign o_rdy_pin_oe          = rif.pin_oe;
  assign o_offset_corr_en      = cfg0_reg[`AFE_BIT_OFFCORR];
  assign o_gain_corr_en        = cfg0_reg[`AFE_BIT_GAINCORR];
  assign o_strength_a          = afe_strength_a_t'(cfg0_reg[`AFE_POS_STRENGTH_A +: 2]);
  assign o_bias_current_select = afe_bias_t'(cfg0_reg[`AFE_POS_BIAS +: 2]);
  assign o_osr_ratio = `AFE_OSR_BASE << cfg0_reg[`AFE_POS_OSR +: 3];
  assign o_ref_trim            = cfg0_reg[7:0];
  assign o_analog_master_clock_en            = analog_master_clock_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_crc_lengthens: assert property (
    (st_reg == AFE_BUS_IDLE && req && stat_reg[`AFE_BIT_COMMCRC])
      |=> o_avs_waitrequest ##1 !o_avs_waitrequest && o_comm_crc_valid)
    else $error("link checksum did not lengthen the transfer");
  a_crc_message: assert property (
    o_comm_crc_valid |-> o_comm_crc == comm_crc_w)
    else $error("link checksum does not match the transfer");
  a_alarm_pin_low: assert property (
    alarm_reg ##1 alarm_reg |-> !o_rdy_pin_o && o_rdy_pin_oe)
    else $error("alarm does not hold the ready pin low");
  a_alarm_clear_key: assert property (
    $fell(alarm_reg) |-> $past(wr_commit && i_avs_address == (`AFE_IDX_LOCK << 2)
                              && wdata[7:0] == `AFE_UNLOCK_KEY))
    else $error("alarm cleared without the unlock key");
  a_no_alarm_off: assert property (
    !stat_reg[`AFE_BIT_INTEN] && !alarm_reg |=> !alarm_reg)
    else $error("alarm raised while its enable is off");
  a_unimpl_zero: assert property (
    rd_commit && i_avs_address == (`AFE_IDX_STAT << 2) |-> o_avs_readdata[13:6] == 8'h00)
    else $error("unimplemented status bits read nonzero");
  a_flag_on_data: assert property (
    |ev_w |=> (rif.flags & $past(ev_w)) == 6'h00)
    else $error("new data did not clear its ready flag");
  a_status_restore: assert property (
    rif.clr_rd && ev_w == 6'h00 |=> rif.flags == `AFE_FLAGS_RST)
    else $error("status read did not restore the flags");
  a_flags_readonly: assert property (
    wr_commit && ev_w == 6'h00 |=> $stable(rif.flags))
    else $error("a write altered the ready flags");

  c_status_read: cover property (rif.clr_rd && rif.flags != `AFE_FLAGS_RST);
  c_crc_transfer: cover property (o_comm_crc_valid);
  c_alarm_raised: cover property ($rose(alarm_reg));
  c_gain_event: cover property (cfg0_reg[`AFE_BIT_GAINCORR] && |ev_w);
endmodule

// ### sim/afe_conv_model.sv
// Stand-in for the converter datapath that feeds new-data and clock-tick pulses.
// Assumes the bench calls its tasks from one process, on the shared clock.
`timescale 1ns/1ps
module afe_conv_model (
  input  wire logic       i_clk,
  output logic      [5:0] o_chan_new,
  output logic            o_digital_master_clock_tick
);
  initial begin
    o_chan_new   = 6'h00;
    o_digital_master_clock_tick = 1'b0;
  end
  // Pulses last one cycle; a held pulse would look like a second result.
  task automatic new_data(input logic [5:0] m);
    @(posedge i_clk);
    o_chan_new <= m;
    @(posedge i_clk);
    o_chan_new <= 6'h00;
  endtask
  task automatic tick();
    @(posedge i_clk);
    o_digital_master_clock_tick <= 1'b1;
    @(posedge i_clk);
    o_digital_master_clock_tick <= 1'b0;
  endtask
endmodule

// ### sim/test_afe_status_config_regs.sv
// Self-checking bench for the status/link-control and first configuration registers.
// Assumes the converter stand-in model and the design package are compiled first.
`timescale 1ns/1ps
module test_afe_status_config_regs;
  import afe_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [5:0]  chan;
  logic        tick;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest, o_rdy_pin_o, o_rdy_pin_oe, o_comm_crc_valid;
  logic        o_offset_corr_en, o_gain_corr_en, o_analog_master_clock_en;
  logic [15:0] o_comm_crc;
  afe_strength_a_t o_strength_a;
  afe_bias_t   o_bias_current_select;
  logic [12:0] o_osr_ratio;
  logic [7:0]  o_ref_trim;
  logic [23:0] q;
  logic [15:0] cq;
  logic        cv;
  int          lat;
  int          checks = 0;
  int          miscompares = 0;

  always #12.5 i_clk = ~i_clk;

  afe_conv_model u_conv (.i_clk(i_clk), .o_chan_new(chan), .o_digital_master_clock_tick(tick));

  afe_status_config_regs #(.GAIN_DLY(3)) i_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_chan_new(chan), .i_digital_master_clock_tick(tick), .o_rdy_pin_o(o_rdy_pin_o),
    .o_rdy_pin_oe(o_rdy_pin_oe), .o_comm_crc(o_comm_crc),
    .o_comm_crc_valid(o_comm_crc_valid), .o_offset_corr_en(o_offset_corr_en),
    .o_gain_corr_en(o_gain_corr_en), .o_strength_a(o_strength_a),
    .o_bias_current_select(o_bias_current_select), .o_analog_master_clock_en(o_analog_master_clock_en),
    .o_osr_ratio(o_osr_ratio), .o_ref_trim(o_ref_trim));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waitrequest is looked at mid-cycle, which is what the next rising edge will see.
  task automatic bus(input logic w, input logic [7:0] a, input logic [23:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    wr <= w;
    rd <= ~w;
    adr <= a;
    wd <= {8'h00, d};
    do begin
      @(negedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0);
    lat = n;
    @(posedge i_clk);
    cv = o_comm_crc_valid;
    cq = o_comm_crc;
    q = o_avs_readdata[23:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  function automatic logic [15:0] crc16_ref(input logic [47:0] m, input int w);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = w - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction

  task automatic t_reset();
    bus(0, 8'h30, 0);
    chk(q, 24'ha1003f);
    chk(lat, 2);
    bus(0, 8'h34, 0);
    chk(q, 24'h386050);
    chk(o_osr_ratio, 13'd256);
    chk({o_offset_corr_en, o_gain_corr_en}, 0);
    chk(o_rdy_pin_oe, 0);
    bus(0, 8'h40, 0);
    chk(q, 0);
  endtask

  task automatic t_flags();
    u_conv.new_data(6'h04);
    @(negedge i_clk);
    chk({o_rdy_pin_o, o_rdy_pin_oe}, 2'b01);
    @(negedge i_clk);
    chk(o_rdy_pin_oe, 0);
    bus(0, 8'h30, 0);
    chk(q, 24'ha1003b);
    u_conv.new_data(6'h01);
    bus(1, 8'h30, 24'ha10fff);
    bus(0, 8'h34, 0);
    bus(0, 8'h30, 0);
    chk(q, 24'ha1003e);
    bus(0, 8'h30, 0);
    chk(q, 24'ha1003f);
  endtask

  task automatic t_cfg();
    logic [23:0] v;
    int n;
    for (int k = 0; k < 8; k++) begin
      v = {k[0], 1'b0, k[1:0], ~k[1:0], k[1:0], k[2:0], 5'h1f, 8'h50};
      bus(1, 8'h34, v);
      bus(0, 8'h34, 0);
      chk(q, v & 24'hffe0ff);
      chk(o_osr_ratio, 13'h020 << k);
      chk(o_strength_a, k[1:0]);
      chk(o_bias_current_select, 2'(~k[1:0]));
      chk(o_offset_corr_en, k[0]);
      chk(o_ref_trim, 8'h50);
      n = 0;
      repeat (16) begin
        @(negedge i_clk);
        n += o_analog_master_clock_en;
      end
      chk(n, 16 >> k[1:0]);
    end
    bus(1, 8'h34, 24'h386050);
  endtask

  task automatic t_idle();
    bus(1, 8'h30, 24'hb10000);
    repeat (2) @(negedge i_clk);
    chk({o_rdy_pin_o, o_rdy_pin_oe}, 2'b11);
    bus(1, 8'h30, 24'ha10000);
    repeat (2) @(negedge i_clk);
    chk(o_rdy_pin_oe, 0);
  endtask

  task automatic t_crc();
    bus(1, 8'h30, 24'ha18000);
    bus(1, 8'h34, 24'h386050);
    chk(lat, 3);
    chk({cv, cq}, {1'b1, crc16_ref({8'h34, 1'b1, 24'h386050}, 33)});
    bus(0, 8'h30, 0);
    chk(q, 24'ha1803f);
    chk({cv, cq}, {1'b1, crc16_ref({8'h30, 1'b0, 24'ha1803f}, 33)});
    bus(1, 8'h30, 24'ha10000);
    bus(0, 8'h40, 0);
    chk({lat[7:0], cv}, {8'd2, 1'b0});
  endtask

  task automatic t_alarm();
    bus(1, 8'h84, 0);
    bus(1, 8'h34, 24'h386051);
    repeat (3) @(negedge i_clk);
    chk(o_rdy_pin_oe, 0);
    bus(0, 8'h80, 0);
    chk(q, crc16_ref({24'ha10000, 24'h386051}, 48));
    bus(1, 8'h84, 24'h0000a5);
    bus(1, 8'h30, 24'ha14000);
    bus(1, 8'h84, 0);
    bus(1, 8'h34, 24'h386052);
    repeat (4) @(negedge i_clk);
    chk({o_rdy_pin_o, o_rdy_pin_oe}, 2'b01);
    bus(1, 8'h84, 24'h00003c);
    repeat (3) @(negedge i_clk);
    chk({o_rdy_pin_o, o_rdy_pin_oe}, 2'b01);
    bus(1, 8'h84, 24'h0000a5);
    repeat (2) @(negedge i_clk);
    chk(o_rdy_pin_oe, 0);
    bus(1, 8'h30, 24'ha10000);
    bus(1, 8'h34, 24'h386050);
  endtask

  task automatic t_gain();
    bus(1, 8'h34, 24'h786050);
    @(negedge i_clk);
    chk(o_gain_corr_en, 1);
    u_conv.new_data(6'h02);
    @(negedge i_clk);
    chk(o_rdy_pin_oe, 0);
    // The result waits for the next step, then three more steps of the line.
    repeat (3) u_conv.tick();
    bus(0, 8'h30, 0);
    chk(q, 24'ha1003f);
    u_conv.tick();
    @(negedge i_clk);
    chk({o_rdy_pin_o, o_rdy_pin_oe}, 2'b01);
    bus(0, 8'h30, 0);
    chk(q, 24'ha1003d);
    bus(1, 8'h34, 24'h386050);
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_flags();
    t_cfg();
    t_idle();
    t_crc();
    t_alarm();
    t_gain();
    complete_run();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (5000) @(posedge i_clk);
    miscompares++;
    $display("BAD %0t run did not finish in time", $time);
    complete_run();
  end
endmodule
